//--- design/eic_top.sv
// Summary of operation
// - Two external lines, active only in input mode
// - Select 00: falling edge sets pending flag
// - Select 10: rising edge sets pending flag
// - Select 11: either edge sets pending flag
// - Select 01: low level sets pending flag
// - Low level: clearing fails while pin low
// - Pending flag is the request, never auto-cleared
// - Software may set or clear any flag
// - Thirteen sources: two external, eleven internal
// - Internal sources are the listed peripherals
// - Sources split into five group requests
// - Per-source enable bits in three registers
// - Per-group enable bits in group register
// - Global enable masks every interrupt
// - Line flags at bits 0 and 1
`include "eic_map.svh"
`timescale 1ns/1ps
`default_nettype none
module eic_top
    import eic_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [4:0][23:0] GROUP_MEMBERS = {`EIC_GRP_E, `EIC_GRP_D,
        `EIC_GRP_C, `EIC_GRP_B, `EIC_GRP_A}
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ext_int_line_one, // External pin, line one
    input wire logic ext_int_line_two, // External pin, line two
    input wire logic [1:0] line_is_input, // Port direction, 1 = input
    input wire eic_src_s src_set, // Internal set pulses
    output logic [4:0] irq_group, // Group requests to the core
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam eic_idx_t IDX_NONE = 4'hF;
    localparam logic [2:0][7:0] REQ_MASK = {`EIC_REQ2_MASK,
        `EIC_REQ1_MASK, `EIC_REQ0_MASK};

    logic [2:0][7:0] request_reg; // Pending flags, registers 0..2
    logic [2:0][7:0] source_enable_reg; // Per-source enables
    logic [7:0] group_enable_reg; // Group enables and global enable
    logic [7:0] ext_trigger_config_reg; // Trigger modes of both lines
    logic [2:0][7:0] hw_set; // Hardware set requests
    logic [1:0] ext_evt; // Detector outputs
    logic [4:0] irq_group_reg; // Registered group requests
    logic awready_reg, wready_reg, bvalid_reg; // Write channel outputs
    logic [1:0] bresp_reg;
    logic arready_reg; // Read channel outputs
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    eic_rd_state_e rd_state_reg;
    logic aw_hold_reg, w_hold_reg; // Address and data caught
    logic [ADDR_W-1:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic do_write; // Both halves present, perform write
    eic_idx_t wr_idx, rd_idx;
    logic [31:0] rdata_next;

    // Map a byte address onto a register index
    function automatic eic_idx_t addr_idx(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_W'(`EIC_OFF_REQ0): addr_idx = 4'h0;
            ADDR_W'(`EIC_OFF_REQ1): addr_idx = 4'h1;
            ADDR_W'(`EIC_OFF_REQ2): addr_idx = 4'h2;
            ADDR_W'(`EIC_OFF_SEN0): addr_idx = 4'h3;
            ADDR_W'(`EIC_OFF_SEN1): addr_idx = 4'h4;
            ADDR_W'(`EIC_OFF_SEN2): addr_idx = 4'h5;
            ADDR_W'(`EIC_OFF_GEN): addr_idx = 4'h6;
            ADDR_W'(`EIC_OFF_TRIG): addr_idx = 4'h7;
            ADDR_W'(`EIC_OFF_STAT): addr_idx = 4'h8;
            default: addr_idx = IDX_NONE;
        endcase
    endfunction : addr_idx

    // Detectors for the two external lines
    eic_ext_line u_line_one (
        .mclk(mclk),
        .nrst(nrst),
        .pin(ext_int_line_one),
        .is_input(line_is_input[0]),
        .mode(eic_trig_e'(ext_trigger_config_reg[1:0])),
        .evt(ext_evt[0])
    );
    eic_ext_line u_line_two (
        .mclk(mclk),
        .nrst(nrst),
        .pin(ext_int_line_two),
        .is_input(line_is_input[1]),
        .mode(eic_trig_e'(ext_trigger_config_reg[3:2])),
        .evt(ext_evt[1])
    );

    // Place every source on its flag bit
    always_comb begin
        hw_set = '0;
        hw_set[0][1:0] = ext_evt;
        hw_set[1][`EIC_BIT_LOCK] = src_set.lock;
        hw_set[1][`EIC_BIT_TXF] = src_set.tx_fifo;
        hw_set[1][`EIC_BIT_RXF] = src_set.rx_fifo;
        hw_set[1][`EIC_BIT_SPI] = src_set.spi;
        hw_set[1][`EIC_BIT_SNR] = src_set.snr;
        hw_set[1][`EIC_BIT_SWD] = src_set.signaling_word;
        hw_set[2][`EIC_BIT_WDT] = src_set.watchdog;
        hw_set[2][`EIC_BIT_LBD] = src_set.battery_level_detector;
        hw_set[2][`EIC_BIT_CT2] = src_set.capture_two;
        hw_set[2][`EIC_BIT_CT1] = src_set.capture_one;
        hw_set[2][`EIC_BIT_TBT] = src_set.time_base;
    end

    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_idx = addr_idx(awaddr_reg);
    assign rd_idx = addr_idx(s_axi_araddr);

    // Flag and enable registers; a hardware set wins over a clear
    for (genvar g = 0; g < 3; g++) begin : g_req
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                request_reg[g] <= `EIC_RST_BYTE;
                source_enable_reg[g] <= `EIC_RST_BYTE;
            end else begin
                if (do_write && wstrb0_reg && wr_idx == eic_idx_t'(g)) begin
                    // Software write; set wins, flag sticks on low pin
                    request_reg[g] <= (wdata_reg | hw_set[g])
                        & REQ_MASK[g];
                end else begin
                    // Flag holds until software clears it
                    request_reg[g] <= (request_reg[g] | hw_set[g])
                        & REQ_MASK[g];
                end
                if (do_write && wstrb0_reg
                        && wr_idx == eic_idx_t'(g + 3)) begin
                    source_enable_reg[g] <= wdata_reg
                        & REQ_MASK[g];
                end
            end
        end
    end

    // Group enable and trigger configuration
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            group_enable_reg <= `EIC_RST_BYTE;
            ext_trigger_config_reg <= `EIC_RST_BYTE;
        end else if (do_write && wstrb0_reg) begin
            if (wr_idx == 4'h6) begin
                group_enable_reg <= wdata_reg & 8'h9F;
            end
            if (wr_idx == 4'h7) begin
                ext_trigger_config_reg <= wdata_reg & 8'h0F;
            end
        end
    end

    // Group requests toward the core
    for (genvar k = 0; k < 5; k++) begin : g_grp
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                irq_group_reg[k] <= 1'b0;
            end else begin
                irq_group_reg[k] <= (|(request_reg & source_enable_reg
                    & GROUP_MEMBERS[k])) && group_enable_reg[k]
                    && group_enable_reg[`EIC_BIT_GLOBAL];
            end
        end
    end

    // Write address channel
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            awready_reg <= 1'b0;
            aw_hold_reg <= 1'b0;
            awaddr_reg <= '0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_reg <= 1'b0;
            end else if (!aw_hold_reg && !bvalid_reg) begin
                awready_reg <= 1'b1;
            end
        end
    end

    // Write data channel
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wready_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            wdata_reg <= `EIC_RST_BYTE;
            wstrb0_reg <= 1'b0;
        end else begin
            if (s_axi_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_hold_reg <= 1'b0;
            end else if (!w_hold_reg && !bvalid_reg) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // Write response; unmapped address answers an error
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `EIC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_idx == IDX_NONE) ? `EIC_RESP_SLVERR
                : `EIC_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read data selection
    always_comb begin
        rdata_next = '0;
        case (rd_idx)
            4'h0, 4'h1, 4'h2: rdata_next[7:0] = request_reg[rd_idx[1:0]];
            4'h3: rdata_next[7:0] = source_enable_reg[0];
            4'h4: rdata_next[7:0] = source_enable_reg[1];
            4'h5: rdata_next[7:0] = source_enable_reg[2];
            4'h6: rdata_next[7:0] = group_enable_reg;
            4'h7: rdata_next[7:0] = ext_trigger_config_reg;
            4'h8: rdata_next[4:0] = irq_group_reg;
            default: rdata_next = '0;
        endcase
    end

    // Read channel state machine
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_state_reg <= EIC_RD_IDLE;
            arready_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `EIC_RESP_OKAY;
        end else begin
            case (rd_state_reg)
                EIC_RD_IDLE: begin
                    if (s_axi_arvalid && arready_reg) begin
                        arready_reg <= 1'b0;
                        rdata_reg <= rdata_next;
                        rresp_reg <= (rd_idx == IDX_NONE)
                            ? `EIC_RESP_SLVERR : `EIC_RESP_OKAY;
                        rd_state_reg <= EIC_RD_DATA;
                    end else begin
                        arready_reg <= 1'b1;
                    end
                end
                EIC_RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= EIC_RD_IDLE;
                    end
                end
                default: rd_state_reg <= EIC_RD_IDLE;
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign irq_group = irq_group_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rvalid = rd_state_reg[1];

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_low_flag_sticks: assert property (
        (ext_evt[0] && ext_trigger_config_reg[1:0] == 2'h1)
        |=> request_reg[0][0])
        else $error("low level flag cleared while pin low");
    a_flag_no_autoclr: assert property (
        (request_reg[1][`EIC_BIT_LOCK] && !(do_write && wr_idx == 4'h1))
        |=> request_reg[1][`EIC_BIT_LOCK])
        else $error("flag cleared without software");
    a_sw_set_flag: assert property (
        (do_write && wstrb0_reg && wr_idx == 4'h2 && wdata_reg[0])
        |=> request_reg[2][`EIC_BIT_WDT])
        else $error("software set of flag lost");
    a_global_mask: assert property (
        !group_enable_reg[`EIC_BIT_GLOBAL] |=> irq_group_reg == 5'h00)
        else $error("request passed with global enable off");
    a_group_cause: assert property (
        (request_reg[0][0] && source_enable_reg[0][0]
        && group_enable_reg[0] && group_enable_reg[`EIC_BIT_GLOBAL])
        |=> irq_group_reg[0])
        else $error("enabled line one flag gave no request");
    a_src_mask: assert property (
        (source_enable_reg == '0) |=> irq_group_reg == 5'h00)
        else $error("request passed with sources disabled");
    a_ext_evt_set: assert property (
        ext_evt[1] |=> request_reg[0][1])
        else $error("line two event did not set its flag");
    a_bresp_hold: assert property (
        (bvalid_reg && !s_axi_bready) |=> (bvalid_reg && $stable(bresp_reg)))
        else $error("write response dropped early");
endmodule : eic_top
`default_nettype wire

//--- design/eic_map.svh
`ifndef EIC_MAP_SVH
`define EIC_MAP_SVH
// Register byte offsets on the register bus
`define EIC_OFF_REQ0 8'h00
`define EIC_OFF_REQ1 8'h04
`define EIC_OFF_REQ2 8'h08
`define EIC_OFF_SEN0 8'h0C
`define EIC_OFF_SEN1 8'h10
`define EIC_OFF_SEN2 8'h14
`define EIC_OFF_GEN 8'h18
`define EIC_OFF_TRIG 8'h1C
`define EIC_OFF_STAT 8'h20
// Implemented bits of the three request/enable registers
`define EIC_REQ0_MASK 8'h03
`define EIC_REQ1_MASK 8'h77
`define EIC_REQ2_MASK 8'h73
// Bit positions inside request register 1
`define EIC_BIT_LOCK 0
`define EIC_BIT_TXF 1
`define EIC_BIT_RXF 2
`define EIC_BIT_SPI 4
`define EIC_BIT_SNR 5
`define EIC_BIT_SWD 6
// Bit positions inside request register 2
`define EIC_BIT_WDT 0
`define EIC_BIT_LBD 1
`define EIC_BIT_CT2 4
`define EIC_BIT_CT1 5
`define EIC_BIT_TBT 6
// Global enable position in the group enable register
`define EIC_BIT_GLOBAL 7
// Default group membership over the flat 24-bit flag vector
`define EIC_GRP_A 24'h00_0003
`define EIC_GRP_B 24'h00_0700
`define EIC_GRP_C 24'h00_7000
`define EIC_GRP_D 24'h03_0000
`define EIC_GRP_E 24'h70_0000
// Bus responses
`define EIC_RESP_OKAY 2'h0
`define EIC_RESP_SLVERR 2'h2
// Reset value of every control and flag register
`define EIC_RST_BYTE 8'h00
`endif

//--- design/eic_pkg.sv
package eic_pkg;
    // Trigger mode of an external line, {select_hi, select_lo}
    typedef enum logic [1:0] {
        EIC_TRIG_NEG = 2'h0,
        EIC_TRIG_LOW = 2'h1,
        EIC_TRIG_POS = 2'h2,
        EIC_TRIG_BOTH = 2'h3
    } eic_trig_e;
    // Read channel state, one-hot
    typedef enum logic [1:0] {
        EIC_RD_IDLE = 2'h1,
        EIC_RD_DATA = 2'h2
    } eic_rd_state_e;
    // One-cycle set requests from the internal peripherals
    typedef struct packed {
        logic watchdog;
        logic time_base;
        logic capture_one;
        logic capture_two;
        logic spi;
        logic battery_level_detector;
        logic tx_fifo;
        logic rx_fifo;
        logic signaling_word;
        logic snr;
        logic lock;
    } eic_src_s;
    // Register bank as one index into it
    typedef logic [3:0] eic_idx_t;
endpackage : eic_pkg

//--- design/eic_ext_line.sv
`timescale 1ns/1ps
`default_nettype none
module eic_ext_line
    import eic_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin,
    input wire logic is_input,
    input wire eic_trig_e mode,
    output logic evt
);
    logic sync1_reg; // First synchroniser stage
    logic sync2_reg; // Current sample
    logic prev_reg; // Previous sample

    // Two-stage synchroniser and sample history
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Detector; a pin in output mode raises nothing
    always_comb begin
        evt = 1'b0;
        if (is_input) begin
            case (mode)
                EIC_TRIG_NEG: evt = prev_reg && !sync2_reg;
                EIC_TRIG_POS: evt = !prev_reg && sync2_reg;
                EIC_TRIG_BOTH: evt = prev_reg ^ sync2_reg;
                EIC_TRIG_LOW: evt = !sync2_reg;
                default: evt = 1'b0;
            endcase
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_neg_edge_fire: assert property (
        (mode == EIC_TRIG_NEG && is_input) |->
        (evt == ($past(sync2_reg) && !$past(sync1_reg))))
        else $error("falling edge detect wrong");
    a_pos_edge_fire: assert property (
        (mode == EIC_TRIG_POS && is_input) |->
        (evt == ($past(sync1_reg) && !$past(sync2_reg))))
        else $error("rising edge detect wrong");
    a_both_edge_fire: assert property (
        (mode == EIC_TRIG_BOTH && is_input && $stable(mode)) |->
        (evt == ($past(sync1_reg) != $past(sync2_reg))))
        else $error("either edge detect wrong");
    a_low_level_fire: assert property (
        (mode == EIC_TRIG_LOW && is_input) |-> (evt == !$past(sync1_reg)))
        else $error("low level detect wrong");
endmodule : eic_ext_line
`default_nettype wire

//--- dv/eic_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: the two external pins as an outside driver moves them
module eic_pin_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [1:0] level_req, // Levels asked for by the bench
    output logic pin_one, // Line one pin
    output logic pin_two // Line two pin
);
    // Pins change just after an edge; idle level is the inactive high
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_one <= 1'b1; // Pulled high while idle
            pin_two <= 1'b1;
        end else begin
            pin_one <= level_req[0]; // Follows the level asked for by the bench
            pin_two <= level_req[1];
        end
    end
endmodule : eic_pin_model
`default_nettype wire

//--- dv/eic_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eic_top_bench
    import eic_pkg::*;
;
    logic mclk; // System clock
    logic nrst; // Active low reset
    logic [1:0] lvl; // Pin levels asked of the pin model
    logic [1:0] line_is_input; // Port direction per line
    eic_src_s src_set; // Internal set pulses
    wire logic pin1, pin2; // External pins
    logic [4:0] irq_group; // Group requests
    logic [7:0] awaddr, araddr; // Bus addresses
    logic [31:0] wdata, rdata; // Bus data
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp; // Bus responses
    int err_total = 0; // Mismatch count
    int samples_checked = 0; // Comparison count
    int cyc = 0; // Cycle counter for the hang guard

    eic_pin_model pm (.mclk(mclk), .nrst(nrst), .level_req(lvl),
        .pin_one(pin1), .pin_two(pin2));
    eic_top dut (.mclk(mclk), .nrst(nrst), .ext_int_line_one(pin1),
        .ext_int_line_two(pin2), .line_is_input(line_is_input),
        .src_set(src_set), .irq_group(irq_group), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    // Clock generator
    always #5 mclk = ~mclk;

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // Verdict and stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bus write, address and data offered together
    task automatic wr(input int a, input int d, input logic [1:0] er = 2'h0);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        awaddr <= 8'(a);
        wdata <= 32'(d & 255);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge mclk); // Taken with bready standing high
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    // Bus read with expected data and response
    task automatic rd(input int a, input int exp, input logic [1:0] er = 2'h0);
        araddr <= 8'(a);
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge mclk); // Taken with rready standing high
        chk("rresp", 32'(er), 32'(rresp));
        chk("rdata", 32'(exp), rdata);
    endtask : rd

    // Group request check one edge on
    task automatic irq(input int exp);
        @(posedge mclk);
        chk("irq_group", 32'(exp), 32'(irq_group));
    endtask : irq

    // Reset values and unmapped place
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd(4 * i, 0);
        rd(8'h24, 0, 2'h2);
        wr(8'h24, 8'hFF, 2'h2);
    endtask : t_reset

    // Every trigger mode on both lines, fall then rise
    task automatic t_edges();
        logic [3:0] fall;
        logic [3:0] rise;
        fall = 4'b1011;
        rise = 4'b1110;
        for (int ln = 0; ln < 2; ln++) begin
            for (int m = 0; m < 4; m++) begin
                wr(8'h1C, m << (2 * ln));
                repeat (8) @(posedge mclk);
                wr(8'h00, 0);
                lvl[ln] <= 1'b0;
                repeat (8) @(posedge mclk);
                rd(8'h00, fall[m] << ln);
                wr(8'h00, 0);
                rd(8'h00, (m == 1) << ln);
                lvl[ln] <= 1'b1; // Pin back high
                repeat (8) @(posedge mclk);
                rd(8'h00, rise[m] << ln);
                wr(8'h00, 0);
            end
        end
        // Line one in output mode ignores its pin
        line_is_input <= 2'b10;
        wr(8'h1C, 8'h0F);
        lvl <= 2'b00;
        repeat (8) @(posedge mclk);
        rd(8'h00, 2);
        // Back to falling mode before the pins rise, so no edge is caught
        wr(8'h1C, 0);
        lvl <= 2'b11;
        line_is_input <= 2'b11;
        wr(8'h00, 0);
    endtask : t_edges

    // Each internal source through its own, group and global enables
    task automatic t_groups();
        int pos[11] = '{8, 13, 14, 10, 9, 17, 12, 20, 21, 22, 16};
        int r;
        int b;
        int g;
        for (int k = 0; k < 11; k++) begin
            r = pos[k] / 8;
            b = pos[k] % 8;
            g = pos[k] / 4 - 1;
            src_set <= eic_src_s'(11'(1 << k));
            @(posedge mclk);
            src_set <= '0;
            rd(4 * r, 1 << b);
            wr(8'h18, 8'h80 | (1 << g));
            irq(0);
            wr(12 + 4 * r, 1 << b);
            irq(1 << g);
            wr(8'h18, 1 << g);
            irq(0);
            wr(8'h18, 8'h9F & ~(1 << g));
            irq(0);
            wr(8'h18, 8'h9F);
            irq(1 << g);
            wr(4 * r, 0);
            irq(0);
            wr(12 + 4 * r, 0);
        end
    endtask : t_groups

    // Software raises a line flag; it stays until cleared
    task automatic t_soft();
        wr(8'h0C, 3);
        wr(8'h18, 8'h81);
        wr(8'h00, 2);
        irq(1);
        repeat (6) @(posedge mclk);
        irq(1);
        rd(8'h00, 2);
        rd(8'h20, 1);
        wr(8'h00, 0);
        irq(0);
        wr(8'h18, 0);
    endtask : t_soft

    // Main sequence
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        lvl = 2'b11;
        line_is_input = 2'b11;
        src_set = '0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'b11; // Responses always accepted
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_edges();
        t_groups();
        t_soft();
        end_of_test();
    end
endmodule : eic_top_bench
`default_nettype wire
